// file: src/hc_ctrl_consts.vh
// Offsets, field positions, reset values and timing constants of the control/status register set
`ifndef HC_CTRL_CONSTS_VH
`define HC_CTRL_CONSTS_VH

// ==========================================
// Register byte addresses
`define ADDR_SPEC_REVISION 32'h8002_0000
`define ADDR_HOST_MODE_CONTROL 32'h8002_0004
`define ADDR_COMMAND_AND_STATUS 32'h8002_0008

// ==========================================
// Reset values
`define RST_SPEC_REVISION 32'h0000_0010
`define RST_ZERO32 32'h0000_0000
`define SPEC_VERSION_BCD 8'h10

// ==========================================
// host_mode_control fields
`define CBR_LO 0
`define CBR_HI 1
`define PLE_BIT 2
`define ISO_BIT 3
`define CLE_BIT 4
`define BLE_BIT 5
`define FS_LO 6
`define FS_HI 7
`define IR_BIT 8
`define RWW_BIT 9
`define RWO_BIT 10

// ==========================================
// command_and_status fields
`define SRC_BIT 0
`define CLF_BIT 1
`define BLF_BIT 2
`define OCR_BIT 3
`define OVT_LO 16
`define OVT_HI 17

// ==========================================
// Bus states
`define BUS_STATE_RESET 2'h0
`define BUS_STATE_RESUME 2'h1
`define BUS_STATE_RUNNING 2'h2
`define BUS_STATE_SLEEP 2'h3

// ==========================================
// Timing at 125 MHz
`define CLK_PERIOD_NS 8
`define SOF_DELAY_NS 1000000
// Cycle counts are sized to the timer width: 1 ms and 10 us at 8 ns per cycle
`define SOF_DELAY_CYCLES 17'h1_E848
`define SOFT_RESET_NS 10000
`define SOFT_RESET_CYCLES 17'h0_04E2
`define CNT_W 17
`define CNT_ONE 17'h0_0001
`define CNT_ZERO 17'h0_0000

`endif

// file: src/hc_cycle_timer.v
// Down-counting one-shot timer: pulse when a loaded count runs out
`timescale 1ns/100ps
`include "hc_ctrl_consts.vh"

module hc_cycle_timer (
    input wire clk,
    input wire rst,
    input wire start,
    input wire cancel,
    input wire [`CNT_W-1:0] load,
    output reg busy,
    output reg done
);
    reg [`CNT_W-1:0] cnt_reg;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= `CNT_ZERO;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (cancel) begin
                busy <= 1'b0;
            end else if (start) begin
                cnt_reg <= load;
                busy <= 1'b1;
            end else if (busy) begin
                if (cnt_reg == `CNT_ONE) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_reg <= cnt_reg - `CNT_ONE;
            end
        end
    end
endmodule

// file: src/hc_ctrl_status_regs.v
// Control and status register set of the host controller
// Operation
// - Revision register holds read-only BCD version 0x10.
// - Control/bulk ratio 1:1..4:1 decides control versus bulk service.
// - Control service count is kept across frame boundaries.
// - Periodic list enable checked before start; takes effect per frame.
// - Isochronous descriptor with enable clear abandons periodic list.
// - Control list enable checked on each decision; effect per frame.
// - Bulk list enable checked on each decision; effect per frame.
// - Bus state codes: 00 reset, 01 resume, 10 running, 11 sleep.
// - Start-of-frame generation begins 1 ms after entering running.
// - Controller itself changes state only from sleep to resume.
// - Soft reset gives sleep; hard reset gives reset plus port reset.
// - Routing bit picks normal or management interrupt; kept on soft reset.
// - Remote wake wired bit cleared by hard reset only.
// - Wake enable with resume seen signals remote wakeup.
// - Soft reset command moves to sleep, resets registers, self-clears.
// - Soft reset does not reset root hub or drive port reset.
// - Control filled flag gates, is cleared on start, set on finding.
// - Bulk filled flag gates, is cleared on start, set on finding.
// - Ownership request raises change flag; cleared after changeover.
// - Two-bit overrun tally counts every overrun and wraps.
// - Registers are reached through the system bus slave port.
`timescale 1ns/100ps
`include "hc_ctrl_consts.vh"

module hc_ctrl_status_regs (
    // Clock and reset
    input wire REF_CLK,
    input wire RST,
    // Register port from the bus slave
    input wire REG_SEL,
    input wire REG_WRITE,
    input wire [31:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    output reg [31:0] REG_RDATA,
    output wire REG_READY,
    output wire REG_ERROR,
    // List processor
    input wire FRAME_START,
    input wire NONPERIODIC_DECIDE,
    input wire CTRL_ED_SERVED,
    input wire PERIODIC_START_REQ,
    input wire ISO_ED_FOUND,
    input wire CTRL_LIST_BEGIN,
    input wire CTRL_TD_FOUND,
    input wire BULK_LIST_BEGIN,
    input wire BULK_TD_FOUND,
    input wire SCHED_OVERRUN,
    output wire PERIODIC_GO,
    output wire ISO_CONTINUE,
    output wire CTRL_GO,
    output wire BULK_GO,
    output wire SERVE_CTRL_NEXT,
    // Bus state control
    input wire RESUME_DETECT,
    input wire RESUME_SEEN,
    input wire OWNER_CHANGED,
    output wire [1:0] BUS_STATE,
    output reg SOF_ENABLE,
    output wire PORT_RESET_DRIVE,
    output wire ROOT_HUB_RESET,
    output wire SOFT_RESET_BUSY,
    output wire OWNER_CHANGE_SET,
    output wire IRQ_TO_MGMT,
    output wire REMOTE_WAKEUP
);
    // ==========================================
    // Registers
    reg [1:0] ctrl_bulk_ratio_reg;
    reg periodic_list_on_reg;
    reg iso_endpoint_enable_reg;
    reg ctrl_list_on_reg;
    reg bulk_list_on_reg;
    reg [1:0] functional_state_reg;
    reg interrupt_routing_reg;
    reg remote_wake_wired_reg;
    reg remote_wake_on_reg;
    reg soft_reset_cmd_reg;
    reg ctrl_list_filled_reg;
    reg bulk_list_filled_reg;
    reg owner_change_request_reg;
    reg [1:0] overrun_tally_reg;
    reg [2:0] ctrl_served_reg;
    reg port_reset_reg;
    // Frame-latched enables and the previous bus state
    reg periodic_frame_reg;
    reg iso_frame_reg;
    reg ctrl_frame_reg;
    reg bulk_frame_reg;
    reg [1:0] prev_state_reg;

    wire hit_rev = REG_ADDR == `ADDR_SPEC_REVISION;
    wire hit_ctl = REG_ADDR == `ADDR_HOST_MODE_CONTROL;
    wire hit_cmd = REG_ADDR == `ADDR_COMMAND_AND_STATUS;
    wire mapped = hit_rev | hit_ctl | hit_cmd;
    // Bus blocked while soft reset runs
    wire bus_ok = REG_SEL & ~soft_reset_cmd_reg;
    wire wr_ctl = bus_ok & REG_WRITE & hit_ctl;
    wire wr_cmd = bus_ok & REG_WRITE & hit_cmd;
    wire soft_start = wr_cmd & REG_WDATA[`SRC_BIT];
    wire rst_done;
    wire timer_busy;

    assign REG_READY = bus_ok;
    assign REG_ERROR = bus_ok & ~mapped;

    // ==========================================
    // Soft reset duration timer
    hc_cycle_timer u_soft_timer (
        .clk(REF_CLK),
        .rst(RST),
        .start(soft_start),
        .cancel(1'b0),
        .load(`SOFT_RESET_CYCLES),
        .busy(timer_busy),
        .done(rst_done)
    );

    // ==========================================
    // Start-of-frame delay after entering running
    wire enter_run = (functional_state_reg == `BUS_STATE_RUNNING) &&
                     (prev_state_reg != `BUS_STATE_RUNNING);
    wire sof_done;
    wire sof_busy;
    hc_cycle_timer u_sof_timer (
        .clk(REF_CLK),
        .rst(RST),
        .start(enter_run),
        .cancel(functional_state_reg != `BUS_STATE_RUNNING),
        .load(`SOF_DELAY_CYCLES),
        .busy(sof_busy),
        .done(sof_done)
    );

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            prev_state_reg <= `BUS_STATE_RESET;
            SOF_ENABLE <= 1'b0;
        end else begin
            prev_state_reg <= functional_state_reg;
            if (functional_state_reg != `BUS_STATE_RUNNING) begin
                SOF_ENABLE <= 1'b0;
            end else if (sof_done) begin
                SOF_ENABLE <= 1'b1;
            end
        end
    end

    // ==========================================
    // Mode control register
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ctrl_bulk_ratio_reg <= 2'h0;
            periodic_list_on_reg <= 1'b0;
            iso_endpoint_enable_reg <= 1'b0;
            ctrl_list_on_reg <= 1'b0;
            bulk_list_on_reg <= 1'b0;
            functional_state_reg <= `BUS_STATE_RESET;
            interrupt_routing_reg <= 1'b0;
            remote_wake_wired_reg <= 1'b0;
            remote_wake_on_reg <= 1'b0;
            port_reset_reg <= 1'b1;
        end else if (soft_start) begin
            // Routing and wired bits survive soft reset
            ctrl_bulk_ratio_reg <= 2'h0;
            periodic_list_on_reg <= 1'b0;
            iso_endpoint_enable_reg <= 1'b0;
            ctrl_list_on_reg <= 1'b0;
            bulk_list_on_reg <= 1'b0;
            functional_state_reg <= `BUS_STATE_SLEEP;
            remote_wake_on_reg <= 1'b0;
        end else if (wr_ctl) begin
            ctrl_bulk_ratio_reg <= REG_WDATA[`CBR_HI:`CBR_LO];
            periodic_list_on_reg <= REG_WDATA[`PLE_BIT];
            iso_endpoint_enable_reg <= REG_WDATA[`ISO_BIT];
            ctrl_list_on_reg <= REG_WDATA[`CLE_BIT];
            bulk_list_on_reg <= REG_WDATA[`BLE_BIT];
            functional_state_reg <= REG_WDATA[`FS_HI:`FS_LO];
            interrupt_routing_reg <= REG_WDATA[`IR_BIT];
            remote_wake_wired_reg <= REG_WDATA[`RWW_BIT];
            remote_wake_on_reg <= REG_WDATA[`RWO_BIT];
            port_reset_reg <= REG_WDATA[`FS_HI:`FS_LO] == `BUS_STATE_RESET;
        end else if (functional_state_reg == `BUS_STATE_SLEEP && RESUME_DETECT) begin
            functional_state_reg <= `BUS_STATE_RESUME;
        end
    end

    // ==========================================
    // Per-frame latching of list enables
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            periodic_frame_reg <= 1'b0;
            iso_frame_reg <= 1'b0;
            ctrl_frame_reg <= 1'b0;
            bulk_frame_reg <= 1'b0;
        end else if (FRAME_START) begin
            // Changes made mid-frame wait for the next start of frame
            periodic_frame_reg <= periodic_list_on_reg;
            iso_frame_reg <= iso_endpoint_enable_reg;
            ctrl_frame_reg <= ctrl_list_on_reg;
            bulk_frame_reg <= bulk_list_on_reg;
        end
    end

    assign PERIODIC_GO = PERIODIC_START_REQ & periodic_frame_reg;
    assign ISO_CONTINUE = ISO_ED_FOUND & iso_frame_reg;
    assign CTRL_GO = CTRL_LIST_BEGIN & ctrl_frame_reg & ctrl_list_filled_reg;
    assign BULK_GO = BULK_LIST_BEGIN & bulk_frame_reg & bulk_list_filled_reg;
    // Ratio encodes one less than the number of control descriptors
    assign SERVE_CTRL_NEXT = NONPERIODIC_DECIDE & (ctrl_served_reg <= {1'b0, ctrl_bulk_ratio_reg});

    // ==========================================
    // Control service count: not cleared at frame start
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ctrl_served_reg <= 3'h0;
        end else if (soft_start) begin
            ctrl_served_reg <= 3'h0;
        end else if (NONPERIODIC_DECIDE && !SERVE_CTRL_NEXT) begin
            ctrl_served_reg <= 3'h0;
        end else if (CTRL_ED_SERVED && !ctrl_served_reg[2]) begin
            // Saturates at four so a 4:1 ratio cannot wrap back to control
            ctrl_served_reg <= ctrl_served_reg + 3'h1;
        end
    end

    // ==========================================
    // Command and status register
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            soft_reset_cmd_reg <= 1'b0;
            ctrl_list_filled_reg <= 1'b0;
            bulk_list_filled_reg <= 1'b0;
            owner_change_request_reg <= 1'b0;
            overrun_tally_reg <= 2'h0;
        end else begin
            if (soft_start) begin
                soft_reset_cmd_reg <= 1'b1;
            end else if (rst_done) begin
                soft_reset_cmd_reg <= 1'b0;
            end
            if (soft_start) begin
                ctrl_list_filled_reg <= 1'b0;
                bulk_list_filled_reg <= 1'b0;
                owner_change_request_reg <= 1'b0;
                overrun_tally_reg <= 2'h0;
            end else begin
                // Hardware set wins over clear in the same cycle
                if (CTRL_TD_FOUND || (wr_cmd && REG_WDATA[`CLF_BIT])) begin
                    ctrl_list_filled_reg <= 1'b1;
                end else if (CTRL_GO) begin
                    ctrl_list_filled_reg <= 1'b0;
                end
                if (BULK_TD_FOUND || (wr_cmd && REG_WDATA[`BLF_BIT])) begin
                    bulk_list_filled_reg <= 1'b1;
                end else if (BULK_GO) begin
                    bulk_list_filled_reg <= 1'b0;
                end
                if (wr_cmd && REG_WDATA[`OCR_BIT]) begin
                    owner_change_request_reg <= 1'b1;
                end else if (OWNER_CHANGED) begin
                    owner_change_request_reg <= 1'b0;
                end
                if (SCHED_OVERRUN) begin
                    overrun_tally_reg <= overrun_tally_reg + 2'h1;
                end
            end
        end
    end

    assign OWNER_CHANGE_SET = wr_cmd & REG_WDATA[`OCR_BIT];
    assign BUS_STATE = functional_state_reg;
    assign PORT_RESET_DRIVE = port_reset_reg & (functional_state_reg == `BUS_STATE_RESET);
    assign ROOT_HUB_RESET = RST;
    assign SOFT_RESET_BUSY = soft_reset_cmd_reg;
    assign IRQ_TO_MGMT = interrupt_routing_reg;
    assign REMOTE_WAKEUP = remote_wake_on_reg & RESUME_SEEN;

    // ==========================================
    // Read data, registered; reserved bits zero
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= `RST_ZERO32;
        end else if (bus_ok && !REG_WRITE) begin
            REG_RDATA <= `RST_ZERO32;
            if (hit_rev) begin
                REG_RDATA[7:0] <= `SPEC_VERSION_BCD;
            end else if (hit_ctl) begin
                REG_RDATA[`CBR_HI:`CBR_LO] <= ctrl_bulk_ratio_reg;
                REG_RDATA[`PLE_BIT] <= periodic_list_on_reg;
                REG_RDATA[`ISO_BIT] <= iso_endpoint_enable_reg;
                REG_RDATA[`CLE_BIT] <= ctrl_list_on_reg;
                REG_RDATA[`BLE_BIT] <= bulk_list_on_reg;
                REG_RDATA[`FS_HI:`FS_LO] <= functional_state_reg;
                REG_RDATA[`IR_BIT] <= interrupt_routing_reg;
                REG_RDATA[`RWW_BIT] <= remote_wake_wired_reg;
                REG_RDATA[`RWO_BIT] <= remote_wake_on_reg;
            end else if (hit_cmd) begin
                REG_RDATA[`SRC_BIT] <= soft_reset_cmd_reg;
                REG_RDATA[`CLF_BIT] <= ctrl_list_filled_reg;
                REG_RDATA[`BLF_BIT] <= bulk_list_filled_reg;
                REG_RDATA[`OCR_BIT] <= owner_change_request_reg;
                REG_RDATA[`OVT_HI:`OVT_LO] <= overrun_tally_reg;
            end
        end
    end
endmodule

// file: verification/hc_ctrl_status_regs_checker.sv
// Port-level assertions for the control and status register set
`timescale 1ns/100ps
module hc_ctrl_status_regs_checker (
    // Clock and reset
    input logic REF_CLK,
    input logic RST,
    // Register port
    input logic REG_SEL,
    input logic REG_WRITE,
    input logic [31:0] REG_ADDR,
    input logic [31:0] REG_WDATA,
    input logic [31:0] REG_RDATA,
    input logic REG_READY,
    input logic REG_ERROR,
    // Bus state and events
    input logic [1:0] BUS_STATE,
    input logic SOF_ENABLE,
    input logic PORT_RESET_DRIVE,
    input logic ROOT_HUB_RESET,
    input logic SOFT_RESET_BUSY,
    input logic OWNER_CHANGE_SET
);
    // Busy spans the loaded count plus the clearing edge
    localparam int SR_LIMIT = 1251;
    logic acc;
    logic wr_cmd;
    logic [11:0] busy_cnt;
    assign acc = REG_SEL && REG_READY;
    assign wr_cmd = acc && REG_WRITE && REG_ADDR == 32'h8002_0008;
    // A busy that never drops would lock the driver out for good
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            busy_cnt <= 12'h000;
        end else begin
            busy_cnt <= SOFT_RESET_BUSY ? busy_cnt + 12'h001 : 12'h000;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // ==========================================
    // Assertions
    property p_rev_read;
        acc && !REG_WRITE && REG_ADDR == 32'h8002_0000 |=> REG_RDATA[7:0] == 8'h10;
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision read wrong");
    property p_unmapped;
        acc && !(REG_ADDR inside {32'h8002_0000, 32'h8002_0004, 32'h8002_0008}) |-> REG_ERROR;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
    property p_busy_refuse;
        SOFT_RESET_BUSY |-> !REG_READY;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("access taken during soft reset");
    property p_soft_enter;
        wr_cmd && REG_WDATA[0] |=> SOFT_RESET_BUSY && BUS_STATE == 2'h3;
    endproperty
    a_soft_enter: assert property (p_soft_enter) else $error("soft reset did not enter sleep");
    property p_no_port_reset;
        SOFT_RESET_BUSY |-> !ROOT_HUB_RESET && !PORT_RESET_DRIVE;
    endproperty
    a_no_port_reset: assert property (p_no_port_reset) else $error("soft reset drove port reset");
    property p_state_own;
        $changed(BUS_STATE) && !$past(acc && REG_WRITE) && !SOFT_RESET_BUSY |->
            $past(BUS_STATE) == 2'h3 && BUS_STATE == 2'h1;
    endproperty
    a_state_own: assert property (p_state_own) else $error("state changed on its own");
    property p_owner;
        wr_cmd && REG_WDATA[3] |-> OWNER_CHANGE_SET;
    endproperty
    a_owner: assert property (p_owner) else $error("ownership request not raised");
    property p_sof_delay;
        $rose(BUS_STATE == 2'h2) |-> (!SOF_ENABLE) [*8];
    endproperty
    a_sof_delay: assert property (p_sof_delay) else $error("frame start came too early");
    property p_busy_len;
        busy_cnt <= SR_LIMIT;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("soft reset too long");
endmodule
bind hc_ctrl_status_regs hc_ctrl_status_regs_checker hc_ctrl_status_regs_checker_i (
    .REF_CLK(REF_CLK), .RST(RST), .REG_SEL(REG_SEL), .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_READY(REG_READY), .REG_ERROR(REG_ERROR),
    .BUS_STATE(BUS_STATE), .SOF_ENABLE(SOF_ENABLE), .PORT_RESET_DRIVE(PORT_RESET_DRIVE),
    .ROOT_HUB_RESET(ROOT_HUB_RESET), .SOFT_RESET_BUSY(SOFT_RESET_BUSY), .OWNER_CHANGE_SET(OWNER_CHANGE_SET)
);

// file: verification/hc_host_driver_model.sv
// Host driver model: master of the register port
`timescale 1ns/100ps
module hc_host_driver_model (
    // Clock
    input logic REF_CLK,
    // Register port toward the block
    output logic REG_SEL,
    output logic REG_WRITE,
    output logic [31:0] REG_ADDR,
    output logic [31:0] REG_WDATA,
    input logic REG_READY,
    input logic REG_ERROR,
    input logic [31:0] REG_RDATA
);
    initial begin
        REG_SEL = 1'b0;
        REG_WRITE = 1'b0;
        REG_ADDR = 32'h0000_0000;
        REG_WDATA = 32'h0000_0000;
    end
    // Whole word only; held until ready is seen at a rising edge or 3000 more edges pass
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        int n;
        n = 0;
        @(negedge REF_CLK);
        REG_SEL = 1'b1;
        REG_WRITE = wr;
        REG_ADDR = addr;
        REG_WDATA = wr ? wdata : ~REG_WDATA;
        @(posedge REF_CLK);
        while (REG_READY !== 1'b1 && n < 3000) begin
            @(posedge REF_CLK);
            n++;
        end
        err = REG_ERROR;
        @(negedge REF_CLK);
        rdata = REG_RDATA;
        // Released lines toggle so a stale value cannot pass
        REG_SEL = 1'b0;
        REG_ADDR = ~addr;
        REG_WRITE = ~wr;
    endtask
endmodule

// file: verification/hc_ctrl_status_regs_tb_top.sv
// Self-checking bench for the control and status register set
`timescale 1ns/100ps
module hc_ctrl_status_regs_tb_top;
    localparam logic [31:0] A_REV = 32'h8002_0000;
    localparam logic [31:0] A_CTL = 32'h8002_0004;
    localparam logic [31:0] A_CMD = 32'h8002_0008;
    localparam logic [31:0] M_CTL = 32'h0000_07FF;
    localparam logic [31:0] M_CMD = 32'h0003_000F;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_sel, reg_write, reg_ready, reg_error, er;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic frame_start = 1'b0, np_decide = 1'b0, ctrl_ed_served = 1'b0, sched_overrun = 1'b0;
    logic periodic_req = 1'b0, iso_found = 1'b0, ctrl_begin = 1'b0, bulk_begin = 1'b0;
    logic ctrl_td_found = 1'b0, bulk_td_found = 1'b0, resume_detect = 1'b0, resume_seen = 1'b0;
    logic owner_changed = 1'b0;
    logic periodic_go, iso_continue, ctrl_go, bulk_go, serve_ctrl_next, sof_enable, port_reset_drive;
    logic root_hub_reset, soft_reset_busy, owner_change_set, irq_to_mgmt, remote_wakeup;
    logic [1:0] bus_state;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    hc_ctrl_status_regs hc_ctrl_status_regs_i (
        .REF_CLK(ref_clk), .RST(rst), .REG_SEL(reg_sel), .REG_WRITE(reg_write), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_READY(reg_ready), .REG_ERROR(reg_error),
        .FRAME_START(frame_start), .NONPERIODIC_DECIDE(np_decide), .CTRL_ED_SERVED(ctrl_ed_served),
        .PERIODIC_START_REQ(periodic_req), .ISO_ED_FOUND(iso_found), .CTRL_LIST_BEGIN(ctrl_begin),
        .CTRL_TD_FOUND(ctrl_td_found), .BULK_LIST_BEGIN(bulk_begin), .BULK_TD_FOUND(bulk_td_found),
        .SCHED_OVERRUN(sched_overrun), .PERIODIC_GO(periodic_go), .ISO_CONTINUE(iso_continue),
        .CTRL_GO(ctrl_go), .BULK_GO(bulk_go), .SERVE_CTRL_NEXT(serve_ctrl_next), .RESUME_DETECT(resume_detect),
        .RESUME_SEEN(resume_seen), .OWNER_CHANGED(owner_changed), .BUS_STATE(bus_state), .SOF_ENABLE(sof_enable),
        .PORT_RESET_DRIVE(port_reset_drive), .ROOT_HUB_RESET(root_hub_reset), .SOFT_RESET_BUSY(soft_reset_busy),
        .OWNER_CHANGE_SET(owner_change_set), .IRQ_TO_MGMT(irq_to_mgmt), .REMOTE_WAKEUP(remote_wakeup)
    );
    hc_host_driver_model hc_host_driver_model_i (
        .REF_CLK(ref_clk), .REG_SEL(reg_sel), .REG_WRITE(reg_write), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_READY(reg_ready), .REG_ERROR(reg_error), .REG_RDATA(reg_rdata)
    );
    always #4 ref_clk = ~ref_clk;
    // ==========================================
    // Tasks
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        hc_host_driver_model_i.xfer(1'b1, a, d, rd, er);
    endtask
    // Reserved bits may read as anything, so only the mask is compared
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
        hc_host_driver_model_i.xfer(1'b0, a, 32'h0000_0000, rd, er);
        check(rd & m, exp);
    endtask
    // Decision is held across one edge, so a refused control turn clears the count
    task automatic decide(input logic [31:0] exp);
        @(negedge ref_clk);
        np_decide = 1'b1;
        #1;
        check(32'(serve_ctrl_next), exp);
        @(negedge ref_clk);
        np_decide = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask
    // Begin requests are held over one edge, which also consumes the filled flags
    task automatic lists(input logic [3:0] exp);
        @(negedge ref_clk);
        {periodic_req, iso_found, ctrl_begin, bulk_begin} = 4'hF;
        #1;
        check(32'({periodic_go, iso_continue, ctrl_go, bulk_go}), 32'(exp));
        @(negedge ref_clk);
        {periodic_req, iso_found, ctrl_begin, bulk_begin} = 4'h0;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (3) @(negedge ref_clk);
        check(32'({root_hub_reset, port_reset_drive}), 32'h0000_0003);
        rst = 1'b0;
        check(32'(bus_state), 32'h0000_0000);
        rd_chk(A_REV, 32'h0000_00FF, 32'h0000_0010);
        wr(A_REV, 32'hFFFF_FFFF);
        rd_chk(A_REV, 32'h0000_00FF, 32'h0000_0010);
        rd_chk(A_CTL, M_CTL, 32'h0000_0000);
        rd_chk(A_CMD, M_CMD, 32'h0000_0000);
        hc_host_driver_model_i.xfer(1'b0, 32'h8002_000C, 32'h0000_0000, rd, er);
        check(32'(er), 32'h0000_0001);
        $display("test reset values done");
        for (int r = 0; r < 4; r++) begin
            wr(A_CTL, 32'(r));
            repeat (r) pulse(ctrl_ed_served);
            pulse(frame_start);
            decide(32'h0000_0001);
            pulse(ctrl_ed_served);
            decide(32'h0000_0000);
            pulse(np_decide);
        end
        $display("test service ratio done");
        wr(A_CMD, 32'h0000_0006);
        wr(A_CTL, 32'h0000_003C);
        lists(4'h0);
        pulse(frame_start);
        lists(4'hF);
        rd_chk(A_CMD, M_CMD, 32'h0000_0000);
        lists(4'hC);
        pulse(ctrl_td_found);
        pulse(bulk_td_found);
        rd_chk(A_CMD, M_CMD, 32'h0000_0006);
        wr(A_CTL, 32'h0000_0000);
        lists(4'hF);
        pulse(frame_start);
        lists(4'h0);
        $display("test list gating done");
        for (int i = 1; i < 6; i++) begin
            pulse(sched_overrun);
            rd_chk(A_CMD, M_CMD, 32'(i % 4) << 16);
        end
        wr(A_CMD, 32'h0000_0008);
        rd_chk(A_CMD, M_CMD, 32'h0001_0008);
        pulse(owner_changed);
        rd_chk(A_CMD, M_CMD, 32'h0001_0000);
        $display("test overrun and ownership done");
        wr(A_CTL, 32'h0000_0780);
        check(32'({bus_state, sof_enable}), 32'h0000_0004);
        check(32'({irq_to_mgmt, remote_wakeup}), 32'h0000_0002);
        @(negedge ref_clk);
        resume_seen = 1'b1;
        #1;
        check(32'(remote_wakeup), 32'h0000_0001);
        wr(A_CMD, 32'h0000_0001);
        check(32'({soft_reset_busy, bus_state, root_hub_reset, port_reset_drive}), 32'h0000_001C);
        rd_chk(A_CTL, M_CTL, 32'h0000_03C0);
        rd_chk(A_CMD, M_CMD, 32'h0000_0000);
        check(32'({irq_to_mgmt, remote_wakeup}), 32'h0000_0002);
        @(negedge ref_clk);
        resume_detect = 1'b1;
        @(negedge ref_clk);
        check(32'(bus_state), 32'h0000_0001);
        resume_detect = 1'b0;
        $display("test soft reset and resume done");
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        check(32'({root_hub_reset, port_reset_drive}), 32'h0000_0003);
        rst = 1'b0;
        rd_chk(A_CTL, M_CTL, 32'h0000_0000);
        $display("test hard reset done");
        summarize();
    end
endmodule
